// file: rtl/ulf_top.sv
`timescale 1ns/10ps
module ulf_top (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Enhanced feature bits from the channel.
  input wire logic [7:0] enhanced_feature_bits,
  // Data and divisor register contents at shared offsets.
  input wire logic [7:0] rx_data_in,
  input wire logic [7:0] div_low_in,
  input wire logic [7:0] divisor_high_byte,
  input wire logic [7:0] int_enable_in,
  input wire logic [7:0] line_status_in,
  input wire logic [7:0] queue_ready_in,
  output logic data_sel_wr,
  output logic divisor_sel_wr,
  // Queue levels and events.
  input wire logic [6:0] rx_level,
  input wire logic [6:0] tx_space,
  input wire logic rx_timeout,
  output logic rx_irq,
  output logic tx_irq,
  output logic rxq_reset,
  output logic txq_reset,
  output logic queue_enabled,
  // Serial frame shaping.
  input wire logic tx_shift_bit,
  input wire logic [7:0] char_data,
  output logic tx_line,
  output logic [3:0] word_bits,
  output logic [3:0] stop_half_bits,
  output logic parity_used,
  output logic parity_bit,
  // Resume-on-any.
  input wire logic rx_char_stb,
  input wire logic rx_char_is_flow,
  input wire logic sw_flow_active,
  output logic tx_resume,
  output logic rx_store,
  // Modem pins.
  input wire logic cts_n_pin,
  input wire logic dsr_n_pin,
  input wire logic ri_n_pin,
  input wire logic cd_n_pin,
  input wire logic auto_rts_en,
  input wire logic auto_rts_n,
  output logic dtr_n,
  output logic rts_n,
  output logic user_output_two,
  output logic loopback_on,
  output logic int_out,
  output logic int_oe,
  input wire logic int_req,
  // Modem status delta bits supplied by channel logic.
  input wire logic [3:0] msr_delta
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] line_format_control_q;
  logic [7:0] modem_output_control_q;
  logic [7:0] scratch_pad_q;
  logic [7:0] queue_thresholds_q;
  logic [7:0] halt_resume_levels_q;
  logic [7:0] queue_control_q;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic enh;
  logic ext_on;
  logic key_on;
  logic [7:0] modem_input_status;
  logic [7:0] rdata_d;

  function automatic logic [6:0] rx_trig(input logic [1:0] code);
    case (code)
      2'h0: rx_trig = ulf_pkg::TRIG_8;
      2'h1: rx_trig = ulf_pkg::TRIG_16;
      2'h2: rx_trig = ulf_pkg::TRIG_56;
      default: rx_trig = ulf_pkg::TRIG_60;
    endcase
  endfunction : rx_trig

  function automatic logic [6:0] tx_trig(input logic [1:0] code);
    case (code)
      2'h0: tx_trig = ulf_pkg::TRIG_8;
      2'h1: tx_trig = ulf_pkg::TRIG_16;
      2'h2: tx_trig = ulf_pkg::TRIG_32;
      default: tx_trig = ulf_pkg::TRIG_56;
    endcase
  endfunction : tx_trig

  // Queue-ready flags take offset 7 whenever loopback is off, user output one is set and the key value is not loaded.
  // The banked-access bits do not matter then, so reads and writes share this one decode.
  function automatic logic ready_sel(input logic [7:0] moc);
    ready_sel = {moc[ulf_pkg::MOC_LOOP], moc[ulf_pkg::MOC_OP1]} == ulf_pkg::OPEN_LOOP;
  endfunction : ready_sel

  assign enh = enhanced_feature_bits[ulf_pkg::EFR_ENH];
  assign ext_on = enh && modem_output_control_q[ulf_pkg::MOC_EXT];
  assign key_on = (line_format_control_q == ulf_pkg::LFC_ENH_KEY);

  ////////////////////////////////////////////////////////////////////////////
  // Modem pins are asynchronous, so they pass two flops first.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end
    else
    begin
      pin_s1_q <= {cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin};
      pin_s2_q <= pin_s1_q;
    end
  end

  always_comb
  begin
    if (modem_output_control_q[ulf_pkg::MOC_LOOP])
    begin
      modem_input_status[4] = modem_output_control_q[ulf_pkg::MOC_RTS];
      modem_input_status[5] = modem_output_control_q[ulf_pkg::MOC_DTR];
      modem_input_status[6] = modem_output_control_q[ulf_pkg::MOC_OP1];
      modem_input_status[7] = modem_output_control_q[ulf_pkg::MOC_OP2];
    end
    else
    begin
      modem_input_status[7:4] = ~pin_s2_q;
    end
    modem_input_status[3:0] = msr_delta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The format register stays writable with the key value loaded, so software can leave it.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      line_format_control_q <= ulf_pkg::LFC_RESET;
    else if (reg_wr && reg_addr == ulf_pkg::ADDR_LFC)
      line_format_control_q <= reg_wdata;
  end

  // Enhanced-only bits keep their value when the enhanced bit is clear.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      modem_output_control_q <= ulf_pkg::MOC_RESET;
    else if (reg_wr && reg_addr == ulf_pkg::ADDR_MOC && !key_on)
    begin
      modem_output_control_q[4:0] <= reg_wdata[4:0];
      if (enh)
        modem_output_control_q[7:5] <= reg_wdata[7:5];
    end
  end

  // Without the enable bit a queue-control write only drops the enable.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      queue_control_q <= ulf_pkg::ZERO8;
    else if (reg_wr && reg_addr == ulf_pkg::ADDR_QCTL && !key_on
             && reg_wdata[ulf_pkg::QC_EN])
    begin
      queue_control_q <= reg_wdata;
      if (!enh)
        queue_control_q[5:4] <= queue_control_q[5:4];
    end
    else if (reg_wr && reg_addr == ulf_pkg::ADDR_QCTL && !key_on)
      queue_control_q[ulf_pkg::QC_EN] <= 1'b0;
  end

  assign rxq_reset = reg_wr && reg_addr == ulf_pkg::ADDR_QCTL && !key_on
                     && reg_wdata[ulf_pkg::QC_EN] && reg_wdata[1];
  assign txq_reset = reg_wr && reg_addr == ulf_pkg::ADDR_QCTL && !key_on
                     && reg_wdata[ulf_pkg::QC_EN] && reg_wdata[2];
  assign queue_enabled = queue_control_q[ulf_pkg::QC_EN];

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      scratch_pad_q <= ulf_pkg::SPR_RESET;
    else if (reg_wr && reg_addr == ulf_pkg::ADDR_SPR && !key_on && !ext_on
             && !ready_sel(modem_output_control_q))
      scratch_pad_q <= reg_wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      queue_thresholds_q <= ulf_pkg::ZERO8;
    else if (reg_wr && reg_addr == ulf_pkg::ADDR_SPR && !key_on && ext_on
             && !ready_sel(modem_output_control_q))
      queue_thresholds_q <= reg_wdata;
  end

  // Halt and resume levels hide behind the modem status and need the banked access.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      halt_resume_levels_q <= ulf_pkg::ZERO8;
    else if (reg_wr && reg_addr == ulf_pkg::ADDR_MSR && !key_on && ext_on)
      halt_resume_levels_q <= reg_wdata;
  end

  // Divisor access steers writes at offsets 0 and 1 to the baud divisor latches.
  assign data_sel_wr = reg_wr && reg_addr == ulf_pkg::ADDR_DATA
                       && !line_format_control_q[ulf_pkg::LFC_DLAB];
  assign divisor_sel_wr = reg_wr && reg_addr <= ulf_pkg::ADDR_IER
                          && line_format_control_q[ulf_pkg::LFC_DLAB];

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped or write-only locations read zero.
  always_comb
  begin
    rdata_d = ulf_pkg::ZERO8;
    if (reg_addr == ulf_pkg::ADDR_DATA)
      rdata_d = line_format_control_q[ulf_pkg::LFC_DLAB] ? div_low_in : rx_data_in;
    else if (reg_addr == ulf_pkg::ADDR_IER)
      rdata_d = line_format_control_q[ulf_pkg::LFC_DLAB] ? divisor_high_byte
                                                          : int_enable_in;
    else if (reg_addr == ulf_pkg::ADDR_LFC)
      rdata_d = line_format_control_q;
    else if (reg_addr == ulf_pkg::ADDR_MOC)
      rdata_d = modem_output_control_q;
    else if (reg_addr == ulf_pkg::ADDR_STAT)
      rdata_d = line_status_in;
    else if (reg_addr == ulf_pkg::ADDR_MSR)
      rdata_d = ext_on ? halt_resume_levels_q : modem_input_status;
    else if (reg_addr == ulf_pkg::ADDR_SPR)
    begin
      if (key_on)
        rdata_d = scratch_pad_q;
      else if (ready_sel(modem_output_control_q))
        rdata_d = queue_ready_in;
      else if (ext_on)
        rdata_d = queue_thresholds_q;
      else
        rdata_d = scratch_pad_q;
    end
  end

  // Read data stand for one cycle only, so a stale value is never mistaken for a new one.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata <= ulf_pkg::ZERO8;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= ulf_pkg::ZERO8;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive interrupt uses strictly greater than the threshold.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rx_irq <= 1'b0;
      tx_irq <= 1'b0;
    end
    else
    begin
      rx_irq <= (rx_level > rx_trig(queue_control_q[7:6])) || rx_timeout;
      tx_irq <= tx_space > tx_trig(queue_control_q[5:4]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame shape: word length, stop length in half bits, parity.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      word_bits <= 4'h6;
      stop_half_bits <= ulf_pkg::HALF_BITS_2;
    end
    else
    begin
      word_bits <= {2'h0, line_format_control_q[1:0]} + 4'h5;
      if (!line_format_control_q[ulf_pkg::LFC_STOP])
        stop_half_bits <= ulf_pkg::HALF_BITS_1;
      else if (line_format_control_q[1:0] == 2'h0)
        stop_half_bits <= ulf_pkg::HALF_BITS_15;
      else
        stop_half_bits <= ulf_pkg::HALF_BITS_2;
    end
  end

  // Parity covers only the selected data bits, so higher bits are masked.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      parity_used <= 1'b0;
      parity_bit <= 1'b0;
    end
    else
    begin
      parity_used <= line_format_control_q[ulf_pkg::LFC_PEN];
      if (line_format_control_q[ulf_pkg::LFC_FORCE])
        parity_bit <= ~line_format_control_q[ulf_pkg::LFC_EVEN];
      else
        parity_bit <= ^(char_data & (8'hff >> (2'h3 - line_format_control_q[1:0])))
                      ^ ~line_format_control_q[ulf_pkg::LFC_EVEN];
    end
  end

  // Break overrides the shifter until software clears the bit.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      tx_line <= 1'b1;
    else
      tx_line <= tx_shift_bit && !line_format_control_q[ulf_pkg::LFC_BRK];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tx_resume <= 1'b0;
      rx_store <= 1'b0;
    end
    else
    begin
      tx_resume <= rx_char_stb && modem_output_control_q[ulf_pkg::MOC_XANY];
      rx_store <= rx_char_stb && !(modem_output_control_q[ulf_pkg::MOC_XANY]
                  && rx_char_is_flow && sw_flow_active);
    end
  end

  // Pins follow the modem control bits in loopback too; only loopback_on shows the mode.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      user_output_two <= 1'b1;
      loopback_on <= 1'b0;
      int_oe <= 1'b0;
      int_out <= 1'b0;
    end
    else
    begin
      dtr_n <= ~modem_output_control_q[ulf_pkg::MOC_DTR];
      rts_n <= auto_rts_en ? auto_rts_n : ~modem_output_control_q[ulf_pkg::MOC_RTS];
      user_output_two <= ~modem_output_control_q[ulf_pkg::MOC_OP2];
      loopback_on <= modem_output_control_q[ulf_pkg::MOC_LOOP];
      int_oe <= modem_output_control_q[ulf_pkg::MOC_OP2];
      int_out <= int_req;
    end
  end

endmodule : ulf_top

// file: rtl/ulf_pkg.sv
package ulf_pkg;
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_QCTL = 3'h2;
  localparam logic [2:0] ADDR_LFC = 3'h3;
  localparam logic [2:0] ADDR_MOC = 3'h4;
  localparam logic [2:0] ADDR_STAT = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_SPR = 3'h7;
  localparam logic [7:0] LFC_ENH_KEY = 8'hbf;
  localparam logic [7:0] LFC_RESET = 8'h05;
  localparam logic [7:0] MOC_RESET = 8'h00;
  localparam logic [7:0] SPR_RESET = 8'hff;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam int LFC_DLAB = 7;
  localparam int LFC_BRK = 6;
  localparam int LFC_FORCE = 5;
  localparam int LFC_EVEN = 4;
  localparam int LFC_PEN = 3;
  localparam int LFC_STOP = 2;
  localparam int MOC_DTR = 0;
  localparam int MOC_RTS = 1;
  localparam int MOC_OP1 = 2;
  localparam int MOC_OP2 = 3;
  localparam int MOC_LOOP = 4;
  localparam int MOC_XANY = 5;
  localparam int MOC_EXT = 6;
  localparam int EFR_ENH = 4;
  localparam int QC_EN = 0;
  localparam logic [6:0] TRIG_8 = 7'h08;
  localparam logic [6:0] TRIG_16 = 7'h10;
  localparam logic [6:0] TRIG_32 = 7'h20;
  localparam logic [6:0] TRIG_56 = 7'h38;
  localparam logic [6:0] TRIG_60 = 7'h3c;
  localparam logic [3:0] HALF_BITS_1 = 4'h2;
  localparam logic [3:0] HALF_BITS_15 = 4'h3;
  localparam logic [3:0] HALF_BITS_2 = 4'h4;
  localparam logic [1:0] OPEN_LOOP = 2'h1;
  typedef enum logic [1:0] {ULF_PAR_NONE, ULF_PAR_ODD, ULF_PAR_EVEN, ULF_PAR_FIXED} ulf_par_e;
endpackage : ulf_pkg

// file: testbench/ulf_sva.sv
`timescale 1ns/10ps
module ulf_sva (
  // Clock, reset and register port.
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic data_sel_wr,
  input wire logic divisor_sel_wr,
  // Queue and frame outputs.
  input wire logic [6:0] rx_level,
  input wire logic rx_timeout,
  input wire logic rx_irq,
  input wire logic tx_line,
  input wire logic [3:0] word_bits,
  input wire logic [3:0] stop_half_bits,
  input wire logic parity_used,
  // Modem outputs.
  input wire logic dtr_n,
  input wire logic user_output_two,
  input wire logic int_oe
);
  logic [7:0] lfc_q;
  logic lfc_wr;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Shadow of the format register, so checks need no look inside the block.
  assign lfc_wr = reg_wr && reg_addr == 3'h3;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      lfc_q <= 8'h05;
    else if (lfc_wr)
      lfc_q <= reg_wdata;
  end
  sequence s_set;
    lfc_wr ##1 !lfc_wr;
  endsequence
  ////////////////////////////////////////
  a_word_len: assert property (s_set |=> word_bits == 4'h5 + {2'h0, lfc_q[1:0]})
    else $error("word length wrong");
  a_stop_len: assert property (s_set |=> stop_half_bits == (!lfc_q[2] ? 4'h2 :
    lfc_q[1:0] == 2'h0 ? 4'h3 : 4'h4)) else $error("stop length wrong");
  a_parity_on: assert property (s_set |=> parity_used == lfc_q[3])
    else $error("parity enable wrong");
  a_break_low: assert property (s_set |=> !lfc_q[6] || !tx_line)
    else $error("break not held low");
  a_div_map: assert property (reg_wr && reg_addr == 3'h0 |->
    divisor_sel_wr == lfc_q[7] && data_sel_wr == !lfc_q[7]) else $error("bad data map");
  a_dtr_drive: assert property (reg_wr && reg_addr == 3'h4 && lfc_q != 8'hbf ##1 !reg_wr
    |=> dtr_n == !$past(reg_wdata[0], 2)) else $error("dtr level wrong");
  a_op2_oe: assert property (user_output_two != int_oe)
    else $error("user output two not inverse of enable");
  a_rx_irq_hi: assert property (rx_level > 7'h3c || rx_timeout |=> rx_irq)
    else $error("receive interrupt missing");
  a_rx_irq_lo: assert property (rx_level <= 7'h08 && !rx_timeout |=> !rx_irq)
    else $error("receive interrupt early");
  c_break: cover property (lfc_wr && reg_wdata[6]);
  c_rx_irq: cover property (rx_irq);
  c_div: cover property (divisor_sel_wr);
endmodule : ulf_sva
bind ulf_top ulf_sva u_sva (.*);

// file: testbench/ulf_modem_model.sv
`timescale 1ns/10ps
module ulf_modem_model (
  // Clock and serial line.
  input wire logic core_clk,
  input wire logic tx_line,
  // Pin levels commanded by the bench.
  input wire logic [3:0] pin_set,
  output logic cts_n_pin,
  output logic dsr_n_pin,
  output logic ri_n_pin,
  output logic cd_n_pin,
  output logic brk_seen
);
  logic [4:0] low_q;
  assign {cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin} = pin_set;
  // A space of 16 clocks stands in for a full frame, since no baud timing exists here.
  always_ff @(posedge core_clk)
  begin
    if (tx_line)
      low_q <= 5'h00;
    else if (!low_q[4])
      low_q <= low_q + 5'h01;
  end
  assign brk_seen = low_q[4];
endmodule : ulf_modem_model

// file: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, enhanced_feature_bits = 8'h00;
  logic [7:0] rx_data_in = 8'h3c, div_low_in = 8'hc3, divisor_high_byte = 8'h12;
  logic [7:0] int_enable_in = 8'h00, line_status_in = 8'h60, queue_ready_in = 8'h81;
  logic [7:0] char_data = 8'h35;
  logic [6:0] rx_level = 7'h00, tx_space = 7'h00;
  logic rx_timeout = 1'b0, tx_shift_bit = 1'b1, rx_char_stb = 1'b0, rx_char_is_flow = 1'b0;
  logic sw_flow_active = 1'b1, auto_rts_en = 1'b0, auto_rts_n = 1'b0, int_req = 1'b0;
  logic [3:0] msr_delta = 4'h0, pin_set = 4'ha, word_bits, stop_half_bits;
  logic data_sel_wr, divisor_sel_wr, rx_irq, tx_irq, rxq_reset, txq_reset, queue_enabled;
  logic tx_line, parity_used, parity_bit, tx_resume, rx_store, dtr_n, rts_n;
  logic user_output_two, loopback_on, int_out, int_oe, brk_seen, pe;
  logic cts_n_pin, dsr_n_pin, ri_n_pin, cd_n_pin, sel_d, sel_v, rxr, txr;
  logic [6:0] rx_thr [4] = '{7'h08, 7'h10, 7'h38, 7'h3c};
  logic [6:0] tx_thr [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
  int mismatches = 0;
  int checks_done = 0;
  int i;
  ulf_top DUT (.*);
  ulf_modem_model u_modem (.*);
  always #20 core_clk = ~core_clk;
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Comb strobes are captured mid-cycle, while the write stands.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(negedge core_clk);
    {sel_d, sel_v, rxr, txr} = {data_sel_wr, divisor_sel_wr, rxq_reset, txq_reset};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle
  task automatic pulse(input logic fl, input logic [7:0] exp);
    @(posedge core_clk);
    rx_char_is_flow <= fl;
    rx_char_stb <= 1'b1;
    @(posedge core_clk);
    rx_char_stb <= 1'b0;
    @(negedge core_clk);
    chk({6'h0, tx_resume, rx_store}, exp);
  endtask : pulse
  task automatic report_and_stop;
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  // The tests need about three hundred clocks; the limit of 25000 clocks leaves wide margin.
  initial
  begin
    #1000000;
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(3'h3, 8'h05);
    rd(3'h7, 8'hff);
    chk({word_bits, stop_half_bits}, 8'h64);
    chk({5'h0, dtr_n, user_output_two, loopback_on}, 8'h06);
    for (i = 0; i < 8; i++)
    begin
      wr(3'h3, 8'(i));
      settle();
      chk({4'h0, word_bits}, 8'(5 + i % 4));
      chk({4'h0, stop_half_bits}, i < 4 ? 8'h02 : i == 4 ? 8'h03 : 8'h04);
      chk({7'h0, parity_used}, 8'h00);
    end
    for (i = 0; i < 8; i++)
    begin
      wr(3'h3, {2'h0, 2'(i % 4), 2'h2, i < 4 ? 2'h0 : 2'h3});
      settle();
      pe = i % 4 == 0 ? !(i < 4) : i % 4 == 1 ? (i < 4) : i % 4 == 2;
      chk({6'h0, parity_used, parity_bit}, {6'h0, 1'b1, pe});
    end
    wr(3'h3, 8'h43);
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    chk({6'h0, tx_line, brk_seen}, 8'h01);
    wr(3'h3, 8'h03);
    settle();
    chk({6'h0, tx_line, brk_seen}, 8'h02);
    wr(3'h0, 8'h11);
    chk({6'h0, sel_d, sel_v}, 8'h02);
    rd(3'h0, 8'h3c);
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h11);
    chk({6'h0, sel_d, sel_v}, 8'h01);
    rd(3'h0, 8'hc3);
    rd(3'h1, 8'h12);
    wr(3'h3, 8'h03);
    wr(3'h4, 8'h0b);
    settle();
    chk({4'h0, dtr_n, rts_n, user_output_two, int_oe}, 8'h01);
    @(posedge core_clk);
    {auto_rts_en, auto_rts_n} <= 2'h3;
    int_req <= 1'b1;
    settle();
    chk({7'h0, rts_n}, 8'h01);
    chk({7'h0, int_out}, 8'h01);
    @(posedge core_clk);
    auto_rts_en <= 1'b0;
    rd(3'h6, 8'h50);
    wr(3'h4, 8'h14);
    settle();
    chk({7'h0, loopback_on}, 8'h01);
    rd(3'h6, 8'h40);
    rd(3'h7, 8'hff);
    wr(3'h4, 8'h04);
    rd(3'h7, 8'h81);
    wr(3'h4, 8'h60);
    rd(3'h4, 8'h00);
    rd(3'h6, 8'h50);
    @(posedge core_clk);
    enhanced_feature_bits <= 8'h10;
    wr(3'h4, 8'h40);
    rd(3'h4, 8'h40);
    wr(3'h6, 8'h5a);
    rd(3'h6, 8'h5a);
    wr(3'h7, 8'ha5);
    rd(3'h7, 8'ha5);
    wr(3'h4, 8'h00);
    rd(3'h7, 8'hff);
    rd(3'h6, 8'h50);
    wr(3'h3, 8'hbf);
    wr(3'h4, 8'h01);
    wr(3'h3, 8'h03);
    rd(3'h4, 8'h00);
    wr(3'h2, 8'h07);
    chk({6'h0, rxr, txr}, 8'h03);
    wr(3'h2, 8'h06);
    settle();
    chk({5'h0, rxr, txr, queue_enabled}, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      wr(3'h2, {2'(i), 2'(i), 4'h1});
      {rx_level, tx_space} <= {rx_thr[i], tx_thr[i]};
      settle();
      chk({6'h0, rx_irq, tx_irq}, 8'h00);
      @(posedge core_clk);
      {rx_level, tx_space} <= {rx_thr[i] + 7'h01, tx_thr[i] + 7'h01};
      settle();
      chk({6'h0, rx_irq, tx_irq}, 8'h03);
      @(posedge core_clk);
      {rx_level, tx_space} <= 14'h0;
    end
    rx_timeout <= 1'b1;
    settle();
    chk({7'h0, rx_irq}, 8'h01);
    @(posedge core_clk);
    rx_timeout <= 1'b0;
    wr(3'h4, 8'h20);
    pulse(1'b0, 8'h03);
    pulse(1'b1, 8'h02);
    report_and_stop();
  end
endmodule : tb_top
